// *** bench/uab_term_model.sv ***
/*
  Remote terminal model: sends framed characters on the receive line.
  Assumes the bench clock and a line that idles high between frames.
*/
`timescale 1ns/1ps
module uab_term_model (
  // Clock
  input wire logic core_clk,
  // Serial line
  output logic serial_receive_pin
);
  initial serial_receive_pin = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Start bit, eight data bits LSB first, one stop bit, then idle high
  task automatic send_char(input logic [7:0] ch, input int bit_cyc);
    logic [9:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk);
      serial_receive_pin = frame[i];
      repeat (bit_cyc - 1) @(negedge core_clk);
    end
  endtask : send_char
endmodule : uab_term_model

// *** bench/uab_top_tb_top.sv ***
/*
  Self-checking bench of the auto-baud engine, transmit gate and scratch byte.
  Assumes the design contract of zero wait state APB and a 10 MHz core clock.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module uab_top_tb_top;
  import uab_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  uab_apb_req_t apb_req;
  logic [31:0] apb_prdata;
  logic apb_pready, apb_pslverr, serial_receive_pin;
  uab_frac_t frac;
  logic end_measure_irq_enable, measure_timeout_irq_enable;
  logic end_measure_irq_flag, measure_timeout_irq_flag;
  logic [15:0] div_value;
  logic div_load, rsr_reset, rsr_fast, rsr_sample;
  logic thr_valid, tsr_busy, tx_load;
  int seed = 9;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_samp, n_rsr, n_load, n_tx, busy_cnt;
  logic tx_on = 1'b0;
  logic gate_exp = 1'b1;
  logic p_valid, p_busy, p_gate, p_load;
  logic [31:0] rdata;
  logic err;
  logic [7:0] v;

  uab_top u_dut (.core_clk, .rst, .apb_req, .apb_prdata, .apb_pready, .apb_pslverr,
    .serial_receive_pin, .frac, .end_measure_irq_enable, .measure_timeout_irq_enable,
    .end_measure_irq_flag, .measure_timeout_irq_flag, .div_value, .div_load,
    .rsr_reset, .rsr_fast, .rsr_sample, .thr_valid, .tsr_busy, .tx_load);
  uab_term_model u_term (.core_clk, .serial_receive_pin);

  always #50 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse counters and load qualification
  always @(posedge core_clk) begin
    if (rsr_sample === 1'b1) n_samp <= n_samp + 1;
    if (rsr_reset === 1'b1) n_rsr <= n_rsr + 1;
    if (div_load === 1'b1) n_load <= n_load + 1;
    if (tx_load === 1'b1) begin
      n_tx <= n_tx + 1;
      `CHK({p_valid, p_busy, p_gate, p_load}, 4'b1010)
    end
    p_valid <= thr_valid;
    p_busy <= tsr_busy;
    p_gate <= gate_exp;
    p_load <= tx_load;
  end

  // Shift register stays busy a few cycles per loaded character
  always @(negedge core_clk) begin
    busy_cnt <= (tx_load === 1'b1) ? 6 : (busy_cnt > 0 ? busy_cnt - 1 : 0);
    tsr_busy <= (tx_load === 1'b1) || (busy_cnt > 1);
    thr_valid <= tx_on & $random(seed);
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_div(input int b, input logic m, input int add,
                                          input int mul);
    int c;
    c = m ? b : 2 * b;
    if (add != 0) c = c * (mul - add) / mul;
    return m ? 16'(c >> 4) : 16'(c >> 5);
  endfunction : exp_div

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(negedge core_clk);
    apb_req = '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(negedge core_clk);
    apb_req.penable = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      if (apb_pready === 1'b1) break;
    end
    rdata = apb_prdata;
    err = apb_pslverr;
    `CHK(apb_pready, 1'b1)
    @(negedge core_clk);
    apb_req.psel = 1'b0;
    apb_req.penable = 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdata, e)
  endtask : rd_chk

  task automatic run_ab(input logic m, input int b, input logic en);
    logic [15:0] e;
    e = exp_div(b, m, frac.add_value, frac.mul_value);
    end_measure_irq_enable = en;
    n_samp = 0;
    n_rsr = 0;
    n_load = 0;
    apb(1'b1, UAB_ADDR_ACR, {30'h0, m, 1'b1});
    rd_chk(UAB_ADDR_ACR, {30'h0, m, 1'b1});
    `CHK({rsr_fast, n_rsr == 1}, 2'b11)
    u_term.send_char(m ? 8'h61 : 8'h41, b);
    repeat (4) @(negedge core_clk);
    `CHK(div_value, e)
    `CHK(n_load, 1)
    `CHK(n_samp, 16)
    `CHK({rsr_fast, end_measure_irq_flag, measure_timeout_irq_flag}, {1'b0, en, 1'b0})
    rd_chk(UAB_ADDR_ACR, {30'h0, m, 1'b0});
    apb(1'b1, UAB_ADDR_ACR, 32'h0);
    `CHK(end_measure_irq_flag, en)
    apb(1'b1, UAB_ADDR_ACR, 32'h300);
    `CHK({end_measure_irq_flag, measure_timeout_irq_flag}, 2'b00)
  endtask : run_ab

  task automatic complete_run();
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    apb_req = '0;
    frac = '0;
    end_measure_irq_enable = 1'b0;
    measure_timeout_irq_enable = 1'b1;
    thr_valid = 1'b0;
    tsr_busy = 1'b0;
    busy_cnt = 0;
    n_tx = 0;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    rd_chk(UAB_ADDR_SCRATCH, 32'h0);
    rd_chk(UAB_ADDR_ACR, 32'h0);
    rd_chk(UAB_ADDR_TER, 32'h80);
    rd_chk(32'hE000C024, 32'h0);
    `CHK(err, 1'b1)
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      apb(1'b1, UAB_ADDR_SCRATCH, {24'h0, v});
      rd_chk(UAB_ADDR_SCRATCH, {24'h0, v});
    end
    `CHK({end_measure_irq_flag, measure_timeout_irq_flag}, 2'b00)
    apb(1'b1, UAB_ADDR_ACR, 32'h6);
    rd_chk(UAB_ADDR_ACR, 32'h6);
    apb(1'b1, UAB_ADDR_ACR, 32'h0);
    // Bit times kept within the supported rate window
    for (int i = 0; i < 4; i++) begin
      run_ab(i[0], 16 * (11 + ($unsigned($random(seed)) % 5)) + 8, i != 1);
    end
    frac = '{add_value: 4'h1, mul_value: 4'h2};
    run_ab(1'b1, 400, 1'b1);
    frac = '0;
    // Abort in mid-count must not load the divisor
    n_load = 0;
    n_samp = 0;
    apb(1'b1, UAB_ADDR_ACR, 32'h1);
    fork
      u_term.send_char(8'h41, 200);
      begin
        repeat (100) @(negedge core_clk);
        apb(1'b1, UAB_ADDR_ACR, 32'h0);
      end
    join
    repeat (4) @(negedge core_clk);
    `CHK({n_load == 0, end_measure_irq_flag, rsr_fast}, 3'b100)
    `CHK(n_samp, 16)
    rd_chk(UAB_ADDR_ACR, 32'h0);
    tx_on = 1'b1;
    repeat (40) @(negedge core_clk);
    `CHK(n_tx != 0, 1'b1)
    apb(1'b1, UAB_ADDR_TER, 32'h0);
    gate_exp = 1'b0;
    repeat (2) @(negedge core_clk);
    n_tx = 0;
    repeat (40) @(negedge core_clk);
    `CHK(n_tx, 0)
    rd_chk(UAB_ADDR_TER, 32'h0);
    apb(1'b1, UAB_ADDR_TER, 32'h80);
    gate_exp = 1'b1;
    n_tx = 0;
    repeat (40) @(negedge core_clk);
    `CHK(n_tx != 0, 1'b1)
    complete_run();
  end
endmodule : uab_top_tb_top

// *** verilog/uab_pkg.sv ***
/*
  Shared constants and types of the auto-baud, transmit-gate and scratch block.
  Assumes a single APB clock domain and the APB byte addresses used here.
*/
package uab_pkg;
  // Register byte addresses
  localparam logic [31:0] UAB_ADDR_SCRATCH = 32'hE000C01C;
  localparam logic [31:0] UAB_ADDR_ACR = 32'hE000C020;
  localparam logic [31:0] UAB_ADDR_TER = 32'hE000C030;
  // Auto-baud control fields
  localparam int UAB_ACR_RUN = 0;
  localparam int UAB_ACR_MODE = 1;
  localparam int UAB_ACR_RESTART = 2;
  localparam int UAB_ACR_END_CLR = 8;
  localparam int UAB_ACR_TO_CLR = 9;
  // Transmit gate field
  localparam int UAB_TER_GATE = 7;
  // Reset values
  localparam logic [7:0] UAB_SCRATCH_RST = 8'h00;
  localparam logic UAB_GATE_RST = 1'b1;
  // Measurement counter: a 2^15 divisor times 16 samples
  localparam int UAB_CNT_W = 19;
  localparam logic [4:0] UAB_START_PULSES = 5'h10;
  localparam logic [15:0] UAB_DIV_MIN = 16'h0001;

  typedef enum logic [1:0] {
    UAB_IDLE = 2'b00,
    UAB_ARMED = 2'b01,
    UAB_MEASURE = 2'b10
  } uab_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } uab_apb_req_t;

  typedef struct packed {
    logic [3:0] add_value;
    logic [3:0] mul_value;
  } uab_frac_t;
endpackage : uab_pkg

// *** verilog/uab_rate_cnt.sv ***
/*
  Measurement counter with optional fractional pre-scaling.
  Assumes clr and run come from the controller in the same clock domain.
*/
`timescale 1ns/1ps
module uab_rate_cnt (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic clr,
  input wire logic run,
  input wire uab_pkg::uab_frac_t frac,
  // Results
  output logic tick,
  output logic ovf,
  output logic [uab_pkg::UAB_CNT_W-1:0] count
);
  import uab_pkg::*;

  logic [3:0] acc_r;
  logic [4:0] acc_sum;
  logic skip;
  logic [UAB_CNT_W-1:0] cnt_r;

  // Fractional add swallows a cycle whenever the accumulator wraps
  assign acc_sum = {1'b0, acc_r} + {1'b0, frac.add_value};
  assign skip = (frac.add_value != 4'h0) && (acc_sum >= {1'b0, frac.mul_value});
  assign tick = run && !skip;
  assign ovf = tick && (&cnt_r);
  assign count = cnt_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_r <= 4'h0;
      cnt_r <= '0;
    end else if (clr) begin
      acc_r <= 4'h0;
      cnt_r <= '0;
    end else if (run) begin
      acc_r <= skip ? 4'(acc_sum - {1'b0, frac.mul_value}) : acc_sum[3:0];
      cnt_r <= tick ? cnt_r + 1'b1 : cnt_r;
    end
  end
endmodule : uab_rate_cnt

// *** verilog/uab_top.sv ***
/*
  Auto-baud measurement engine, transmit gate and scratch byte behind APB.
  Assumes the receive pin is already synchronous to core_clk and that the
  companion receiver and divisor latches sit outside and use the outputs here.
*/
`timescale 1ns/1ps
module uab_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire uab_pkg::uab_apb_req_t apb_req,
  output logic [31:0] apb_prdata,
  output logic apb_pready,
  output logic apb_pslverr,
  // Serial line
  input wire logic serial_receive_pin,
  // Fractional divider and interrupt enables of the companion UART
  input wire uab_pkg::uab_frac_t frac,
  input wire logic end_measure_irq_enable,
  input wire logic measure_timeout_irq_enable,
  // Auto-baud flags
  output logic end_measure_irq_flag,
  output logic measure_timeout_irq_flag,
  // Divisor latch load
  output logic [15:0] div_value,
  output logic div_load,
  // Receive shift register control
  output logic rsr_reset,
  output logic rsr_fast,
  output logic rsr_sample,
  // Transmitter handshake
  input wire logic thr_valid,
  input wire logic tsr_busy,
  output logic tx_load
);
  import uab_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] scratch_r;
  logic run_r;
  logic run_nxt;
  logic mode_r;
  logic restart_r;
  logic gate_r;
  logic end_flag_r;
  logic end_flag_nxt;
  logic to_flag_r;
  logic to_flag_nxt;
  uab_state_t state_r;
  uab_state_t state_nxt;
  logic rx_prev_r;
  logic [4:0] pulses_r;
  logic [15:0] div_r;
  logic div_load_r;
  logic rsr_reset_r;
  logic rsr_fast_r;
  logic rsr_fast_nxt;
  logic rsr_sample_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic setup_ph;
  logic wr_acc;
  logic sel_scr;
  logic sel_acr;
  logic sel_ter;
  logic mapped;
  logic wr_scr;
  logic wr_acr;
  logic wr_ter;
  logic [31:0] rd_mux;

  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign wr_acc = apb_req.psel && apb_req.penable && pready_r && apb_req.pwrite;
  assign sel_scr = apb_req.paddr == UAB_ADDR_SCRATCH;
  assign sel_acr = apb_req.paddr == UAB_ADDR_ACR;
  assign sel_ter = apb_req.paddr == UAB_ADDR_TER;
  assign mapped = sel_scr || sel_acr || sel_ter;
  assign wr_scr = wr_acc && sel_scr;
  assign wr_acr = wr_acc && sel_acr;
  assign wr_ter = wr_acc && sel_ter;

  // Reserved and write-only bits read as zero
  assign rd_mux = sel_scr ? {24'h000000, scratch_r} :
                  sel_acr ? {29'h00000000, restart_r, mode_r, run_r} :
                  sel_ter ? {24'h000000, gate_r, 7'h00} : 32'h00000000;

  // No wait states: answer is prepared during the setup phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= setup_ph ? rd_mux : prdata_r;
      pready_r <= setup_ph;
      pslverr_r <= setup_ph && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scratch and control bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scratch_r <= UAB_SCRATCH_RST;
      mode_r <= 1'b0;
      restart_r <= 1'b0;
      gate_r <= UAB_GATE_RST;
    end else begin
      scratch_r <= wr_scr ? apb_req.pwdata[7:0] : scratch_r;
      mode_r <= wr_acr ? apb_req.pwdata[UAB_ACR_MODE] : mode_r;
      restart_r <= wr_acr ? apb_req.pwdata[UAB_ACR_RESTART] : restart_r;
      gate_r <= wr_ter ? apb_req.pwdata[UAB_TER_GATE] : gate_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement engine
  logic rx_fall;
  logic rx_rise;
  logic start_wr;
  logic abort_wr;
  logic cnt_clr;
  logic cnt_run;
  logic cnt_tick;
  logic cnt_ovf;
  logic [UAB_CNT_W-1:0] cnt_val;
  logic stop_edge;
  logic done;
  logic [15:0] div_calc;
  logic [15:0] div_raw;
  logic sample_nxt;

  assign rx_fall = rx_prev_r && !serial_receive_pin;
  assign rx_rise = !rx_prev_r && serial_receive_pin;
  assign start_wr = wr_acr && apb_req.pwdata[UAB_ACR_RUN];
  assign abort_wr = wr_acr && !apb_req.pwdata[UAB_ACR_RUN];
  // Mode 0 spans start bit plus the data bit that follows it
  assign stop_edge = mode_r ? rx_rise : rx_fall;
  assign done = (state_r == UAB_MEASURE) && stop_edge && !cnt_ovf && !wr_acr;
  assign cnt_clr = start_wr || (state_r != UAB_MEASURE);
  assign cnt_run = state_r == UAB_MEASURE;
  // Counter holds 16 samples per bit; mode 0 covers two bits
  assign div_raw = mode_r ? {1'b0, cnt_val[UAB_CNT_W-1:4]} : {2'b00, cnt_val[UAB_CNT_W-1:5]};
  assign div_calc = (div_raw == 16'h0000) ? UAB_DIV_MIN : div_raw;
  assign sample_nxt = cnt_tick && (pulses_r < UAB_START_PULSES);

  uab_rate_cnt u_rate_cnt (
    .core_clk(core_clk),
    .rst(rst),
    .clr(cnt_clr),
    .run(cnt_run),
    .frac(frac),
    .tick(cnt_tick),
    .ovf(cnt_ovf),
    .count(cnt_val)
  );

  always_comb begin
    state_nxt = state_r;
    run_nxt = run_r;
    rsr_fast_nxt = rsr_fast_r;
    unique case (state_r)
      UAB_IDLE: begin
      end
      UAB_ARMED: begin
        if (rx_fall) begin
          state_nxt = UAB_MEASURE;
        end
      end
      UAB_MEASURE: begin
        if (cnt_ovf && restart_r) begin
          state_nxt = UAB_ARMED;
        end else if (cnt_ovf) begin
          state_nxt = UAB_IDLE;
          run_nxt = 1'b0;
          rsr_fast_nxt = 1'b0;
        end else if (stop_edge) begin
          state_nxt = UAB_IDLE;
          run_nxt = 1'b0;
          rsr_fast_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = UAB_IDLE;
        run_nxt = 1'b0;
      end
    endcase
    // Software write overrides the engine in the same cycle
    if (start_wr) begin
      state_nxt = UAB_ARMED;
      run_nxt = 1'b1;
      rsr_fast_nxt = 1'b1;
    end else if (abort_wr) begin
      state_nxt = UAB_IDLE;
      run_nxt = 1'b0;
      rsr_fast_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= UAB_IDLE;
      run_r <= 1'b0;
      rsr_fast_r <= 1'b0;
      rx_prev_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      run_r <= run_nxt;
      rsr_fast_r <= rsr_fast_nxt;
      rx_prev_r <= serial_receive_pin;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulses_r <= 5'h00;
      rsr_sample_r <= 1'b0;
      rsr_reset_r <= 1'b0;
      div_r <= 16'h0000;
      div_load_r <= 1'b0;
    end else begin
      pulses_r <= cnt_clr ? 5'h00 : (sample_nxt ? pulses_r + 5'h01 : pulses_r);
      rsr_sample_r <= sample_nxt;
      rsr_reset_r <= start_wr;
      div_r <= done ? div_calc : div_r;
      div_load_r <= done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending flags: set wins over a clear in the same cycle
  logic to_set;
  logic end_set;
  logic to_clr;
  logic end_clr;

  assign to_set = cnt_ovf && measure_timeout_irq_enable;
  assign end_set = div_load_r && end_measure_irq_enable;
  assign to_clr = wr_acr && apb_req.pwdata[UAB_ACR_TO_CLR];
  assign end_clr = wr_acr && apb_req.pwdata[UAB_ACR_END_CLR];
  assign to_flag_nxt = to_set || (to_flag_r && !to_clr);
  assign end_flag_nxt = end_set || (end_flag_r && !end_clr);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      to_flag_r <= 1'b0;
      end_flag_r <= 1'b0;
    end else begin
      to_flag_r <= to_flag_nxt;
      end_flag_r <= end_flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit gate
  uab_txgate u_txgate (
    .core_clk(core_clk),
    .rst(rst),
    .gate(gate_r),
    .thr_valid(thr_valid),
    .tsr_busy(tsr_busy),
    .tx_load(tx_load)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign apb_prdata = prdata_r;
  assign apb_pready = pready_r;
  assign apb_pslverr = pslverr_r;
  assign end_measure_irq_flag = end_flag_r;
  assign measure_timeout_irq_flag = to_flag_r;
  assign div_value = div_r;
  assign div_load = div_load_r;
  assign rsr_reset = rsr_reset_r;
  assign rsr_fast = rsr_fast_r;
  assign rsr_sample = rsr_sample_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seq_start_write;
    wr_acr && apb_req.pwdata[UAB_ACR_RUN];
  endsequence

  sequence seq_armed_fast;
    (state_r == UAB_ARMED) && run_r && rsr_fast_r && rsr_reset_r;
  endsequence

  sequence seq_good_stop;
    (state_r == UAB_MEASURE) && stop_edge && !cnt_ovf && !wr_acr;
  endsequence

  chk_scratch_quiet: assert property (
    @(posedge core_clk) disable iff (rst)
    apb_req.psel && sel_scr && !to_set && !end_set |=> $stable(to_flag_r) && $stable(end_flag_r))
    else $error("scratch access changed a flag");

  chk_start_arms: assert property (
    @(posedge core_clk) disable iff (rst) seq_start_write |=> seq_armed_fast)
    else $error("start write did not arm measurement");

  chk_abort_clears: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_acr && !apb_req.pwdata[UAB_ACR_RUN] |=> !run_r && (state_r == UAB_IDLE))
    else $error("abort write left measurement running");

  chk_stop_loads: assert property (
    @(posedge core_clk) disable iff (rst)
    seq_good_stop |=> div_load_r && !run_r && !rsr_fast_r && (div_r == $past(div_calc)))
    else $error("stop edge did not load divisor");

  chk_mode_edge: assert property (
    @(posedge core_clk) disable iff (rst)
    (state_r == UAB_MEASURE) && !mode_r && rx_rise && !wr_acr |=> !div_load_r)
    else $error("mode 0 stopped on a rising edge");

  chk_timeout_flag: assert property (
    @(posedge core_clk) disable iff (rst)
    cnt_ovf && measure_timeout_irq_enable |=> to_flag_r)
    else $error("overflow did not set timeout flag");

  chk_end_flag: assert property (
    @(posedge core_clk) disable iff (rst)
    seq_good_stop ##1 end_measure_irq_enable |=> end_flag_r)
    else $error("completion did not set end flag");

  chk_flag_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    to_clr && !to_set |=> !to_flag_r)
    else $error("timeout flag not cleared");

  chk_restart_rearm: assert property (
    @(posedge core_clk) disable iff (rst)
    cnt_ovf && restart_r && !wr_acr |=> (state_r == UAB_ARMED) && run_r && !div_load_r)
    else $error("overflow with restart did not rearm");

  chk_timeout_end: assert property (
    @(posedge core_clk) disable iff (rst)
    cnt_ovf && !restart_r && !wr_acr |=> !run_r && !div_load_r && $stable(div_r))
    else $error("overflow without restart misbehaved");

  chk_flags_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    end_flag_r && !end_clr |=> end_flag_r)
    else $error("end flag dropped without clear");

  chk_sample_limit: assert property (
    @(posedge core_clk) disable iff (rst)
    pulses_r == UAB_START_PULSES |=> !rsr_sample_r)
    else $error("more than sixteen sampling pulses");
endmodule : uab_top

// *** verilog/uab_txgate.sv ***
/*
  Transmit gate between the holding FIFO and the transmit shift register.
  Assumes tsr_busy stays high while a loaded character is being shifted out.
*/
`timescale 1ns/1ps
module uab_txgate (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic gate,
  // Transmitter handshake
  input wire logic thr_valid,
  input wire logic tsr_busy,
  output logic tx_load
);
  logic load_nxt;
  logic load_r;

  // Gate only blocks new loads; a character in flight finishes
  assign load_nxt = gate && thr_valid && !tsr_busy && !load_r;
  assign tx_load = load_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      load_r <= 1'b0;
    end else begin
      load_r <= load_nxt;
    end
  end

  chk_gate_blocks: assert property (
    @(posedge core_clk) disable iff (rst) !gate |=> !load_r)
    else $error("character loaded while transmit gate closed");
endmodule : uab_txgate
